/* File: dasf_pkg.sv */
/*
 Package for the data addressing and condition flag block: register offsets,
 field positions, reset values, operation and access-mode encodings.
 Assumes a single core clock domain and a plain strobe register port.
*/
package dasf_pkg;

	localparam logic [11:0] DASF_OFF_FLAGS    = 12'hfd8;
	localparam logic [11:0] DASF_OFF_BANK     = 12'hfe0;
	localparam logic [11:0] DASF_OFF_PA_LOW   = 12'hfe9;
	localparam logic [11:0] DASF_OFF_PA_HIGH  = 12'hfea;
	localparam logic [11:0] DASF_OFF_PB_LOW   = 12'hfe1;
	localparam logic [11:0] DASF_OFF_PB_HIGH  = 12'hfe2;
	localparam logic [11:0] DASF_OFF_PC_LOW   = 12'hfd9;
	localparam logic [11:0] DASF_OFF_PC_HIGH  = 12'hfda;
	localparam logic [11:0] DASF_OFF_VOP_A    = 12'hfef;
	localparam logic [11:0] DASF_OFF_VOP_B    = 12'hfe7;
	localparam logic [11:0] DASF_OFF_VOP_C    = 12'hfdf;
	localparam logic [11:0] DASF_OFF_PINC_A   = 12'hfee;
	localparam logic [11:0] DASF_OFF_PINC_B   = 12'hfe6;
	localparam logic [11:0] DASF_OFF_PINC_C   = 12'hfde;
	localparam logic [11:0] DASF_OFF_PDEC_A   = 12'hfed;
	localparam logic [11:0] DASF_OFF_PDEC_B   = 12'hfe5;
	localparam logic [11:0] DASF_OFF_PDEC_C   = 12'hfdd;
	localparam logic [11:0] DASF_OFF_PREI_A   = 12'hfec;
	localparam logic [11:0] DASF_OFF_PREI_B   = 12'hfe4;
	localparam logic [11:0] DASF_OFF_PREI_C   = 12'hfdc;
	localparam logic [11:0] DASF_OFF_PLUSW_A  = 12'hfeb;
	localparam logic [11:0] DASF_OFF_PLUSW_B  = 12'hfe3;
	localparam logic [11:0] DASF_OFF_PLUSW_C  = 12'hfdb;

	localparam int DASF_FLAG_CARRY   = 0;
	localparam int DASF_FLAG_NIBBLE  = 1;
	localparam int DASF_FLAG_ZERO    = 2;
	localparam int DASF_FLAG_OVF     = 3;
	localparam int DASF_FLAG_NEG     = 4;
	localparam logic [7:0] DASF_FLAG_MASK  = 8'h1f;
	localparam logic [7:0] DASF_FLAGS_RST  = 8'h00;
	localparam logic [3:0] DASF_BANK_RST   = 4'h0;
	localparam logic [11:0] DASF_PTR_RST   = 12'h000;

	localparam logic [7:0] DASF_ACCESS_SPLIT   = 8'h60;
	localparam logic [7:0] DASF_INDEX_MAX      = 8'h5f;
	localparam logic [3:0] DASF_ACCESS_HI_BANK = 4'hf;
	localparam logic [11:0] DASF_SFR_BASE      = 12'hfd8;

	typedef enum logic [3:0] {
		DASF_OP_NONE  = 4'h0,
		DASF_OP_ADD   = 4'h1,
		DASF_OP_SUB   = 4'h2,
		DASF_OP_AND   = 4'h3,
		DASF_OP_IOR   = 4'h4,
		DASF_OP_XOR   = 4'h5,
		DASF_OP_MOV   = 4'h6,
		DASF_OP_RRC   = 4'h7,
		DASF_OP_RLC   = 4'h8,
		DASF_OP_CLR   = 4'h9
	} dasf_op_t;

	typedef enum logic [1:0] {
		DASF_AM_DIRECT = 2'h0,
		DASF_AM_FULL   = 2'h1,
		DASF_AM_LITERAL = 2'h2
	} dasf_amode_t;

	typedef struct packed {
		logic        valid;
		dasf_amode_t amode;
		dasf_op_t    op;
		logic [7:0]  file_field;
		logic        access_sel;
		logic        dest_sel;
		logic [11:0] full_addr;
		logic [19:0] jump_target;
		logic [7:0]  literal;
	} dasf_instr_t;

	typedef struct packed {
		logic [7:0] value;
		logic [4:0] flags;
		logic       flags_valid;
	} dasf_alu_out_t;

	typedef enum logic [2:0] {
		DASF_ST_IDLE  = 3'b001,
		DASF_ST_READ  = 3'b010,
		DASF_ST_WRITE = 3'b100
	} dasf_state_t;

	function automatic logic [11:0] dasf_ptr_step(input logic [11:0] p, input logic up);
		dasf_ptr_step = up ? 12'(p + 12'h001) : 12'(p - 12'h001);
	endfunction

endpackage

/* File: dasf_alu.sv */
/*
 Combinational ALU with condition flag generation.
 Assumes operands are stable for the cycle the core samples the result.
*/
`timescale 1ns/100ps
module dasf_alu (
	input  dasf_pkg::dasf_op_t    op,
	input  wire logic [7:0]       opa,
	input  wire logic [7:0]       opw,
	input  wire logic             carry_in,
	output dasf_pkg::dasf_alu_out_t res
);
	import dasf_pkg::*;

	logic [8:0] sum;
	logic [4:0] low_sum;
	logic [7:0] opb;
	logic       cin;

	always_comb begin
		// Subtraction adds the two's complement of the working value
		opb     = (op == DASF_OP_SUB) ? ~opw : opw;
		cin     = (op == DASF_OP_SUB);
		sum     = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
		low_sum = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
		res             = '0;
		res.flags_valid = 1'b1;
		case (op)
			DASF_OP_ADD, DASF_OP_SUB: begin
				res.value = sum[7:0];
				res.flags[DASF_FLAG_CARRY]  = sum[8];
				res.flags[DASF_FLAG_NIBBLE] = low_sum[4];
				res.flags[DASF_FLAG_OVF] = (opa[7] == opb[7]) && (sum[7] != opa[7]);
			end
			DASF_OP_AND: res.value = opa & opw;
			DASF_OP_IOR: res.value = opa | opw;
			DASF_OP_XOR: res.value = opa ^ opw;
			DASF_OP_CLR: res.value = 8'h00;
			DASF_OP_RRC: begin
				res.value = {carry_in, opa[7:1]};
				res.flags[DASF_FLAG_CARRY]  = opa[0];
				res.flags[DASF_FLAG_NIBBLE] = opa[4];
			end
			DASF_OP_RLC: begin
				res.value = {opa[6:0], carry_in};
				res.flags[DASF_FLAG_CARRY]  = opa[7];
				res.flags[DASF_FLAG_NIBBLE] = opa[3];
			end
			DASF_OP_MOV: begin
				res.value       = opa;
				res.flags_valid = 1'b0;
			end
			default: begin
				res.value       = opa;
				res.flags_valid = 1'b0;
			end
		endcase
		res.flags[DASF_FLAG_NEG]  = res.value[7];
		res.flags[DASF_FLAG_ZERO] = (res.value == 8'h00);
	end

endmodule

/* File: dasf_mem.sv */
/*
 Small data memory of 4096 bytes with registered read data.
 Assumes one read or one write per cycle from the addressing core.
*/
`timescale 1ns/100ps
module dasf_mem (
	input  wire logic        clk_sys,
	input  wire logic [11:0] addr,
	input  wire logic        wr_en,
	input  wire logic [7:0]  wr_data,
	output logic      [7:0]  rd_data_q
);
	logic [7:0] store [0:4095];

	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			store[addr] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		rd_data_q <= store[addr];
	end

endmodule

/* File: dasf_core.sv */
/*
 Data addressing and condition flag core: forms 12-bit data addresses
 (direct, access bank, full, indirect, indexed offset), keeps three pointer
 pairs, the bank select register and the flag register, and runs one
 read-modify-write per file-operand instruction over an internal data memory; literal ops skip the read.
 Assumes instruction decode presents one decoded instruction at a time and
 waits while busy is high; register port accesses are from the same clock.
*/
`timescale 1ns/100ps
// Overview of operation
// - Flag register bits seven to five always read as zero.
// - Negative flag follows result bit seven, except on clear and move, which keep it.
// - Overflow flag set when signed add or subtract changes sign wrongly.
// - Zero flag set when the result is zero.
// - Nibble carry flag captures carry out of bit three on add or subtract.
// - Carry flag captures carry out of bit seven on add or subtract.
// - Subtract adds two's complement; carry flags mean no borrow.
// - Rotates load nibble carry from source bit four or bit three.
// - Rotates load carry from the source's top or bottom bit.
// - Literal calls and jumps carry a 20-bit program target.
// - Byte and bit instructions use the low instruction byte as address.
// - Access select one joins bank select with the 8-bit address.
// - Access select zero maps the 8-bit address into the access bank.
// - Full-address instructions such as file moves ignore bank select.
// - Destination bit one writes the file, zero writes the working register.
// - Three pointer pairs of high and low bytes give 12-bit pointers.
// - Virtual operands access memory at their pointer, not their own address.
// - Indirect accesses use the full pointer; bank and access bit ignored.
// - Indirect operands support post-increment, post-decrement, pre-increment, offset.
// - Indexed literal offset works only with the extended set bit at one.
// - Post-increment uses the pointer then adds one across both bytes, no flags.
// - Flag-updating instructions targeting flags block the explicit flag write.
// - Extended mode access bank field up to 5Fh offsets pointer pair c.
module dasf_core (
	input  wire logic                  clk_sys,
	input  wire logic                  reset,
	input  wire logic                  extended_set_config_bit,
	input  dasf_pkg::dasf_instr_t      instr,
	output logic                       busy,
	output logic      [19:0]           jump_target_q,
	output logic      [7:0]            working_q,
	input  wire logic [11:0]           reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [7:0]            reg_rdata_q
);
	import dasf_pkg::*;

	dasf_state_t   state_q;
	dasf_instr_t   instr_q;
	logic [11:0]   ea_q;
	logic [11:0]   ea_d;
	logic [11:0]   ptr_q [0:2];
	logic [3:0]    bank_select_register_q;
	logic [7:0]    flags_q;
	logic [7:0]    flags_d;
	logic [4:0]    flags_owned;
	logic [7:0]    mem_rdata;
	logic [11:0]   mem_addr;
	logic          mem_wr;
	logic [7:0]    mem_wdata;
	logic [7:0]    opa;
	logic          ind_hit;
	logic [1:0]    ind_sel;
	logic [2:0]    ind_kind;
	logic          sfr_hit;
	logic [7:0]    sfr_rdata;
	dasf_alu_out_t alu_res;

	// Virtual operand decode: which pointer and which side effect
	function automatic logic [5:0] vop_decode(input logic [11:0] a);
		case (a)
			DASF_OFF_VOP_A:   vop_decode = {1'b1, 2'd0, 3'd0};
			DASF_OFF_VOP_B:   vop_decode = {1'b1, 2'd1, 3'd0};
			DASF_OFF_VOP_C:   vop_decode = {1'b1, 2'd2, 3'd0};
			DASF_OFF_PINC_A:  vop_decode = {1'b1, 2'd0, 3'd1};
			DASF_OFF_PINC_B:  vop_decode = {1'b1, 2'd1, 3'd1};
			DASF_OFF_PINC_C:  vop_decode = {1'b1, 2'd2, 3'd1};
			DASF_OFF_PDEC_A:  vop_decode = {1'b1, 2'd0, 3'd2};
			DASF_OFF_PDEC_B:  vop_decode = {1'b1, 2'd1, 3'd2};
			DASF_OFF_PDEC_C:  vop_decode = {1'b1, 2'd2, 3'd2};
			DASF_OFF_PREI_A:  vop_decode = {1'b1, 2'd0, 3'd3};
			DASF_OFF_PREI_B:  vop_decode = {1'b1, 2'd1, 3'd3};
			DASF_OFF_PREI_C:  vop_decode = {1'b1, 2'd2, 3'd3};
			DASF_OFF_PLUSW_A: vop_decode = {1'b1, 2'd0, 3'd4};
			DASF_OFF_PLUSW_B: vop_decode = {1'b1, 2'd1, 3'd4};
			DASF_OFF_PLUSW_C: vop_decode = {1'b1, 2'd2, 3'd4};
			default:          vop_decode = 6'h00;
		endcase
	endfunction

	// Plain register read of the mapped pointer, bank and flag bytes
	function automatic logic [8:0] sfr_read(input logic [11:0] a, input logic [7:0] fl,
			input logic [3:0] bk, input logic [11:0] pa, input logic [11:0] pb,
			input logic [11:0] pc);
		case (a)
			DASF_OFF_FLAGS:   sfr_read = {1'b1, fl & DASF_FLAG_MASK};
			DASF_OFF_BANK:    sfr_read = {1'b1, 4'h0, bk};
			DASF_OFF_PA_LOW:  sfr_read = {1'b1, pa[7:0]};
			DASF_OFF_PA_HIGH: sfr_read = {1'b1, 4'h0, pa[11:8]};
			DASF_OFF_PB_LOW:  sfr_read = {1'b1, pb[7:0]};
			DASF_OFF_PB_HIGH: sfr_read = {1'b1, 4'h0, pb[11:8]};
			DASF_OFF_PC_LOW:  sfr_read = {1'b1, pc[7:0]};
			DASF_OFF_PC_HIGH: sfr_read = {1'b1, 4'h0, pc[11:8]};
			default:          sfr_read = 9'h000;
		endcase
	endfunction

	function automatic logic in_mem_space(input logic [11:0] a);
		in_mem_space = (a < DASF_SFR_BASE);
	endfunction

	// Which flag bits an operation drives; logic ops keep carry and overflow
	function automatic logic [4:0] flag_owned(input dasf_op_t o);
		flag_owned = 5'h00;
		case (o)
			DASF_OP_ADD, DASF_OP_SUB: begin
				flag_owned = DASF_FLAG_MASK[4:0];
			end
			DASF_OP_RRC, DASF_OP_RLC: begin
				flag_owned[DASF_FLAG_CARRY]  = 1'b1;
				flag_owned[DASF_FLAG_NIBBLE] = 1'b1;
			end
			default: flag_owned = 5'h00;
		endcase
		if (o != DASF_OP_NONE && o != DASF_OP_MOV) begin
			flag_owned[DASF_FLAG_ZERO] = 1'b1;
			flag_owned[DASF_FLAG_NEG]  = (o != DASF_OP_CLR);
		end
	endfunction

	assign busy = (state_q != DASF_ST_IDLE);

	// Effective address formation
	always_comb begin
		ea_d = {4'h0, instr.file_field};
		case (instr.amode)
			DASF_AM_FULL: ea_d = instr.full_addr;
			DASF_AM_DIRECT: begin
				if (instr.access_sel) begin
					ea_d = {bank_select_register_q, instr.file_field};
				end else if (extended_set_config_bit
						&& instr.file_field <= DASF_INDEX_MAX) begin
					ea_d = 12'(ptr_q[2] + {4'h0, instr.file_field});
				end else if (instr.file_field >= DASF_ACCESS_SPLIT) begin
					ea_d = {DASF_ACCESS_HI_BANK, instr.file_field};
				end else begin
					ea_d = {4'h0, instr.file_field};
				end
			end
			default: ea_d = {4'h0, instr.file_field};
		endcase
	end

	// Indirect redirection: the pointer replaces the operand address
	always_comb begin
		{ind_hit, ind_sel, ind_kind} = vop_decode(ea_q);
		mem_addr = ea_q;
		// Literal ops leave ea_q stale; no pointer side effects from it
		if (instr_q.amode == DASF_AM_LITERAL) begin
			ind_hit = 1'b0;
		end
		if (ind_hit) begin
			case (ind_kind)
				3'd3:    mem_addr = dasf_ptr_step(ptr_q[ind_sel], 1'b1);
				3'd4:    mem_addr = 12'(ptr_q[ind_sel] + {{4{working_q[7]}}, working_q});
				default: mem_addr = ptr_q[ind_sel];
			endcase
		end
		if (state_q == DASF_ST_IDLE && (reg_wr || reg_rd) && in_mem_space(reg_addr)) begin
			mem_addr = reg_addr;
		end
	end

	always_comb begin
		{sfr_hit, sfr_rdata} = sfr_read(ea_q, flags_q, bank_select_register_q,
			ptr_q[0], ptr_q[1], ptr_q[2]);
		// Literal ops take the instruction byte, not a stale file operand
		if (instr_q.amode == DASF_AM_LITERAL) begin
			sfr_hit = 1'b0;
			opa     = instr_q.literal;
		end else begin
			opa = sfr_hit ? sfr_rdata : mem_rdata;
		end
	end

	dasf_alu u_alu (
		.op       (instr_q.op),
		.opa      (opa),
		.opw      (working_q),
		.carry_in (flags_q[DASF_FLAG_CARRY]),
		.res      (alu_res)
	);

	// File write-back only to memory; register-mapped targets handled below
	always_comb begin
		mem_wr    = 1'b0;
		mem_wdata = alu_res.value;
		if (state_q == DASF_ST_WRITE && instr_q.dest_sel
				&& instr_q.amode != DASF_AM_LITERAL && !sfr_hit) begin
			mem_wr = 1'b1;
		end
		if (state_q == DASF_ST_IDLE && reg_wr && in_mem_space(reg_addr)) begin
			mem_wr    = 1'b1;
			mem_wdata = reg_wdata;
		end
	end

	dasf_mem u_mem (
		.clk_sys   (clk_sys),
		.addr      (mem_addr),
		.wr_en     (mem_wr),
		.wr_data   (mem_wdata),
		.rd_data_q (mem_rdata)
	);

	// Sequencer: capture, read operand, write result
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_q <= DASF_ST_IDLE;
			instr_q <= '0;
			ea_q    <= 12'h000;
		end else begin
			case (state_q)
				DASF_ST_IDLE: begin
					if (instr.valid && instr.amode != DASF_AM_LITERAL) begin
						instr_q <= instr;
						ea_q    <= ea_d;
						state_q <= DASF_ST_READ;
					end else if (instr.valid) begin
						instr_q <= instr;
						state_q <= DASF_ST_WRITE;
					end
				end
				DASF_ST_READ:  state_q <= DASF_ST_WRITE;
				DASF_ST_WRITE: state_q <= DASF_ST_IDLE;
				default:       state_q <= DASF_ST_IDLE;
			endcase
		end
	end

	// Literal call and jump targets are latched whole
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			jump_target_q <= 20'h00000;
		end else if (state_q == DASF_ST_IDLE && instr.valid
				&& instr.amode == DASF_AM_LITERAL) begin
			jump_target_q <= instr.jump_target;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			working_q <= 8'h00;
		end else if (state_q == DASF_ST_WRITE
				&& (!instr_q.dest_sel || instr_q.amode == DASF_AM_LITERAL)
				&& instr_q.op != DASF_OP_NONE) begin
			working_q <= alu_res.value;
		end
	end

	// Pointer pairs: side effects happen on the write cycle only
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ptr_q[0] <= DASF_PTR_RST;
			ptr_q[1] <= DASF_PTR_RST;
			ptr_q[2] <= DASF_PTR_RST;
		end else if (state_q == DASF_ST_WRITE && ind_hit) begin
			case (ind_kind)
				3'd1, 3'd3: ptr_q[ind_sel] <= dasf_ptr_step(ptr_q[ind_sel], 1'b1);
				3'd2:       ptr_q[ind_sel] <= dasf_ptr_step(ptr_q[ind_sel], 1'b0);
				default:    ptr_q[ind_sel] <= ptr_q[ind_sel];
			endcase
		end else if (state_q == DASF_ST_WRITE && sfr_hit && instr_q.dest_sel) begin
			case (ea_q)
				DASF_OFF_PA_LOW:  ptr_q[0][7:0]  <= alu_res.value;
				DASF_OFF_PA_HIGH: ptr_q[0][11:8] <= alu_res.value[3:0];
				DASF_OFF_PB_LOW:  ptr_q[1][7:0]  <= alu_res.value;
				DASF_OFF_PB_HIGH: ptr_q[1][11:8] <= alu_res.value[3:0];
				DASF_OFF_PC_LOW:  ptr_q[2][7:0]  <= alu_res.value;
				DASF_OFF_PC_HIGH: ptr_q[2][11:8] <= alu_res.value[3:0];
				default:          ptr_q[0]       <= ptr_q[0];
			endcase
		end else if (state_q == DASF_ST_IDLE && reg_wr) begin
			case (reg_addr)
				DASF_OFF_PA_LOW:  ptr_q[0][7:0]  <= reg_wdata;
				DASF_OFF_PA_HIGH: ptr_q[0][11:8] <= reg_wdata[3:0];
				DASF_OFF_PB_LOW:  ptr_q[1][7:0]  <= reg_wdata;
				DASF_OFF_PB_HIGH: ptr_q[1][11:8] <= reg_wdata[3:0];
				DASF_OFF_PC_LOW:  ptr_q[2][7:0]  <= reg_wdata;
				DASF_OFF_PC_HIGH: ptr_q[2][11:8] <= reg_wdata[3:0];
				default:          ptr_q[0]       <= ptr_q[0];
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			bank_select_register_q <= DASF_BANK_RST;
		end else if (state_q == DASF_ST_WRITE && sfr_hit && instr_q.dest_sel
				&& ea_q == DASF_OFF_BANK) begin
			bank_select_register_q <= alu_res.value[3:0];
		end else if (state_q == DASF_ST_IDLE && reg_wr && reg_addr == DASF_OFF_BANK) begin
			bank_select_register_q <= reg_wdata[3:0];
		end
	end

	// ALU flags win over an explicit write to the flag byte
	always_comb begin
		flags_owned = flag_owned(instr_q.op);
		flags_d     = flags_q;
		if (state_q == DASF_ST_WRITE && alu_res.flags_valid) begin
			flags_d = {3'b000, (flags_q[4:0] & ~flags_owned)
				| (alu_res.flags & flags_owned)};
		end else if (state_q == DASF_ST_WRITE && sfr_hit && instr_q.dest_sel
				&& ea_q == DASF_OFF_FLAGS) begin
			flags_d = alu_res.value & DASF_FLAG_MASK;
		end else if (state_q == DASF_ST_IDLE && reg_wr && reg_addr == DASF_OFF_FLAGS) begin
			flags_d = reg_wdata & DASF_FLAG_MASK;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			flags_q <= DASF_FLAGS_RST;
		end else begin
			flags_q <= flags_d;
		end
	end

	// Read data one cycle after the strobe; memory read is itself registered
	logic rd_mem_q;
	logic [8:0] rd_sfr_q;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rd_mem_q <= 1'b0;
			rd_sfr_q <= 9'h000;
		end else begin
			rd_mem_q <= reg_rd && !busy && in_mem_space(reg_addr);
			rd_sfr_q <= sfr_read(reg_addr, flags_q, bank_select_register_q,
				ptr_q[0], ptr_q[1], ptr_q[2]);
		end
	end

	always_comb begin
		reg_rdata_q = rd_mem_q ? mem_rdata : rd_sfr_q[7:0];
	end

endmodule

/* File: dasf_props.sv */
/*
 Checker for the data addressing and flag core, bound to its ports.
 Assumes one clock domain and the strobe register port of the core.
*/
`timescale 1ns/100ps
module dasf_props (
	input wire logic            clk_sys,
	input wire logic            reset,
	input dasf_pkg::dasf_instr_t instr,
	input wire logic            busy,
	input wire logic [19:0]     jump_target_q,
	input wire logic [7:0]      working_q,
	input wire logic [11:0]     reg_addr,
	input wire logic [7:0]      reg_wdata,
	input wire logic            reg_wr,
	input wire logic            reg_rd,
	input wire logic [7:0]      reg_rdata_q
);
	import dasf_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic take;
	assign take = instr.valid && !busy;
	sequence quiet_s;
		!reg_wr && !instr.valid;
	endsequence

	flags_upper_zero_a: assert property (reg_rd && reg_addr == DASF_OFF_FLAGS |=>
		reg_rdata_q[7:5] == 3'b000) else $error("flag byte top bits not zero");
	ptr_nibble_zero_a: assert property (reg_rd && (reg_addr == DASF_OFF_PA_HIGH ||
		reg_addr == DASF_OFF_PB_HIGH || reg_addr == DASF_OFF_PC_HIGH) |=> reg_rdata_q[7:4] == 4'h0)
		else $error("pointer high nibble not zero");
	flag_readback_a: assert property (reg_wr && reg_addr == DASF_OFF_FLAGS && !busy && !instr.valid
		##1 quiet_s ##1 (reg_rd && reg_addr == DASF_OFF_FLAGS && !instr.valid)
		|=> reg_rdata_q == ($past(reg_wdata, 3) & DASF_FLAG_MASK))
		else $error("flag byte lost its value");
	ptr_readback_a: assert property (reg_wr && reg_addr == DASF_OFF_PA_LOW && !busy && !instr.valid
		##1 quiet_s ##1 (reg_rd && reg_addr == DASF_OFF_PA_LOW && !instr.valid)
		|=> reg_rdata_q == $past(reg_wdata, 3)) else $error("pointer low byte lost its value");
	busy_walk_a: assert property (take && instr.amode != DASF_AM_LITERAL |=>
		busy ##1 busy ##1 !busy) else $error("memory operation walk broken");
	busy_bounded_a: assert property (busy |-> ##[1:2] !busy)
		else $error("busy held too long");
	working_cause_a: assert property (!$stable(working_q) && !$past(reset) |->
		$past(busy) || $past(instr.valid)) else $error("working register changed idle");
	jump_cause_a: assert property (!$stable(jump_target_q) && !$past(reset) |->
		$past(instr.valid) || $past(instr.valid, 2) || $past(instr.valid, 3))
		else $error("jump target changed idle");

	cover property (take && instr.amode == DASF_AM_DIRECT);
	cover property (take && instr.op == DASF_OP_SUB);
	cover property (reg_rd && reg_addr == DASF_OFF_FLAGS);
endmodule

bind dasf_core dasf_props dasf_props_inst (.clk_sys(clk_sys), .reset(reset), .instr(instr),
	.busy(busy), .jump_target_q(jump_target_q), .working_q(working_q), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

/* File: dasf_decode_model.sv */
/*
 Decode-side partner: hands one decoded instruction at a time to the core.
 Assumes the core takes a request only while busy is low.
*/
`timescale 1ns/100ps
module dasf_decode_model (
	input  wire logic            clk_sys,
	input  wire logic            busy,
	output dasf_pkg::dasf_instr_t instr
);
	import dasf_pkg::*;
	initial instr = '0;
	// Waits for completion so requests never overlap
	task automatic issue(input dasf_instr_t i);
		i.valid = 1'b1;
		@(posedge clk_sys);
		instr <= i;
		@(posedge clk_sys);
		instr.valid <= 1'b0;
		for (int n = 0; n < 8; n++) begin
			@(posedge clk_sys);
			#1;
			if (!busy)
				break;
		end
	endtask
endmodule

/* File: data_addressing_status_flags_tb.sv */
/*
 Self-checking bench for the data addressing and flag core.
 Assumes the decode partner model and the bound checker are compiled first.
*/
`timescale 1ns/100ps
module data_addressing_status_flags_tb;
	import dasf_pkg::*;
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic        ext_bit = 1'b0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [11:0] reg_addr = '0;
	logic [7:0]  reg_wdata = '0;
	logic [7:0]  reg_rdata_q, working_q, rd_v;
	logic        busy;
	logic [19:0] jump_target_q;
	dasf_instr_t instr;
	int          num_errors = 0;
	int          samples_checked = 0;
	logic [31:0] seed = 32'h692aca14;
	int          w, l, s;

	always #4 clk_sys = ~clk_sys;

	dasf_core dasf_core_inst (.clk_sys(clk_sys), .reset(reset), .extended_set_config_bit(ext_bit),
		.instr(instr), .busy(busy), .jump_target_q(jump_target_q), .working_q(working_q),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q));
	dasf_decode_model dasf_decode_model_inst (.clk_sys(clk_sys), .busy(busy), .instr(instr));

	function automatic int xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return int'(seed & 32'h0000_00ff);
	endfunction

	function automatic logic [7:0] alu_flags(input int a, input int w, input int s);
		int b, r, h;
		b = s ? (~w & 255) : w;
		r = a + b + s;
		h = a % 16 + b % 16 + s;
		return {3'b000, r[7], (((a ^ b) & 128) == 0) && (((a ^ r) & 128) != 0),
			(r & 255) == 0, h > 15, r > 255};
	endfunction

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_target(input logic [19:0] got, input logic [19:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [11:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rd_v = reg_rdata_q;
	endtask

	task automatic run(input dasf_amode_t m, input dasf_op_t o, input logic [7:0] f,
		input logic a, input logic d, input logic [11:0] fa, input logic [7:0] lt);
		dasf_instr_t i;
		i = '0;
		i.amode = m;
		i.op = o;
		i.file_field = f;
		i.access_sel = a;
		i.dest_sel = d;
		i.full_addr = fa;
		i.literal = lt;
		dasf_decode_model_inst.issue(i);
	endtask

	task automatic lit(input dasf_op_t o, input logic [7:0] v);
		run(DASF_AM_LITERAL, o, 8'h00, 1'b0, 1'b0, 12'h000, v);
	endtask

	task automatic dir(input dasf_op_t o, input logic [7:0] f, input logic a, input logic d);
		run(DASF_AM_DIRECT, o, f, a, d, 12'h000, 8'h00);
	endtask

	task automatic full(input dasf_op_t o, input logic [11:0] fa, input logic d);
		run(DASF_AM_FULL, o, 8'h00, 1'b0, d, fa, 8'h00);
	endtask

	// Clear then add working: stores a byte without a move-to-file op
	task automatic put(input logic [7:0] f, input logic a, input logic [7:0] v);
		lit(DASF_OP_MOV, v);
		dir(DASF_OP_CLR, f, a, 1'b1);
		dir(DASF_OP_ADD, f, a, 1'b1);
	endtask

	task automatic wrap_up();
		$display("errors=%0d checks=%0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		wrap_up();
	end

	initial begin
		dasf_instr_t j;
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		reg_read(DASF_OFF_FLAGS); check_byte(rd_v, 8'h00);
		reg_write(DASF_OFF_FLAGS, 8'hff);
		reg_read(DASF_OFF_FLAGS); check_byte(rd_v, 8'h1f);
		lit(DASF_OP_MOV, 8'h00);
		reg_read(DASF_OFF_FLAGS); check_byte(rd_v, 8'h1f);
		reg_write(DASF_OFF_PA_HIGH, 8'hff);
		reg_read(DASF_OFF_PA_HIGH); check_byte(rd_v, 8'h0f);
		for (int k = 0; k < 32; k++) begin
			w = xs();
			l = xs();
			s = k % 2;
			lit(DASF_OP_MOV, 8'(w));
			lit(s ? DASF_OP_SUB : DASF_OP_ADD, 8'(l));
			check_byte(working_q, 8'(l + (s ? (~w & 255) : w) + s));
			reg_read(DASF_OFF_FLAGS); check_byte(rd_v, alu_flags(l, w, s));
		end
		reg_write(DASF_OFF_BANK, 8'h02);
		put(8'h10, 1'b1, 8'h5a);
		reg_write(DASF_OFF_BANK, 8'h05);
		full(DASF_OP_MOV, 12'h210, 1'b0); check_byte(working_q, 8'h5a);
		lit(DASF_OP_MOV, 8'h01);
		full(DASF_OP_ADD, 12'h210, 1'b0); check_byte(working_q, 8'h5b);
		full(DASF_OP_MOV, 12'h210, 1'b0); check_byte(working_q, 8'h5a);
		put(8'h20, 1'b0, 8'h33);
		full(DASF_OP_MOV, 12'h020, 1'b0); check_byte(working_q, 8'h33);
		reg_write(DASF_OFF_PA_HIGH, 8'h02);
		reg_write(DASF_OFF_PA_LOW, 8'h10);
		reg_read(DASF_OFF_PA_LOW); check_byte(rd_v, 8'h10);
		dir(DASF_OP_MOV, 8'hef, 1'b0, 1'b0); check_byte(working_q, 8'h5a);
		full(DASF_OP_MOV, DASF_OFF_VOP_A, 1'b0); check_byte(working_q, 8'h5a);
		reg_write(DASF_OFF_PB_HIGH, 8'h02);
		reg_write(DASF_OFF_PB_LOW, 8'h0f);
		full(DASF_OP_MOV, DASF_OFF_PREI_B, 1'b0); check_byte(working_q, 8'h5a);
		reg_write(DASF_OFF_BANK, 8'h00);
		put(8'hff, 1'b1, 8'hc3);
		reg_write(DASF_OFF_PA_HIGH, 8'h00);
		reg_write(DASF_OFF_PA_LOW, 8'hff);
		full(DASF_OP_MOV, DASF_OFF_PINC_A, 1'b0); check_byte(working_q, 8'hc3);
		reg_read(DASF_OFF_PA_LOW); check_byte(rd_v, 8'h00);
		reg_read(DASF_OFF_PA_HIGH); check_byte(rd_v, 8'h01);
		put(8'h05, 1'b0, 8'h11);
		ext_bit <= 1'b1;
		reg_write(DASF_OFF_PC_HIGH, 8'h03);
		reg_write(DASF_OFF_PC_LOW, 8'h00);
		put(8'h05, 1'b0, 8'h77);
		ext_bit <= 1'b0;
		dir(DASF_OP_MOV, 8'h05, 1'b0, 1'b0); check_byte(working_q, 8'h11);
		full(DASF_OP_MOV, 12'h305, 1'b0); check_byte(working_q, 8'h77);
		reg_write(DASF_OFF_FLAGS, 8'h00);
		lit(DASF_OP_MOV, 8'h01);
		full(DASF_OP_ADD, DASF_OFF_FLAGS, 1'b1);
		reg_read(DASF_OFF_FLAGS); check_byte(rd_v, alu_flags(0, 1, 0));
		for (int k = 0; k < 4; k++) begin
			put(8'h20, 1'b0, k < 2 ? 8'h01 : 8'h80);
			dir(k % 2 ? DASF_OP_RLC : DASF_OP_RRC, 8'h20, 1'b0, 1'b0);
			reg_read(DASF_OFF_FLAGS);
			check_byte(rd_v & 8'h01, 8'((k == 0 || k == 3) ? 1 : 0));
		end
		j = '0;
		j.amode = DASF_AM_LITERAL;
		j.jump_target = 20'hab5c3;
		dasf_decode_model_inst.issue(j);
		check_target(jump_target_q, 20'hab5c3);
		wrap_up();
	end
endmodule
